// *** rtl/lcdp_defs.vh ***
`ifndef LCDP_DEFS_VH
`define LCDP_DEFS_VH

// ********************************************
// Clock source codes
// ********************************************
`define LCDP_SRC_EXT        2'h0
`define LCDP_SRC_RC_EXTRES  2'h1
`define LCDP_SRC_RC_INTRES  2'h2

// ********************************************
// Start byte layout
// ********************************************
`define LCDP_SB_ID_MSB      7
`define LCDP_SB_ID_LSB      3
`define LCDP_SB_IDSEL_POS   2
`define LCDP_SB_RS_POS      1

// ********************************************
// Instruction codes and fields
// ********************************************
`define LCDP_CMD_NOP        8'h00
`define LCDP_CMD_CLEAR      8'h01
`define LCDP_CMD_HOME       8'h02
`define LCDP_CMD_DUTY_MASK  8'hf8
`define LCDP_CMD_DUTY       8'h18
`define LCDP_CMD_ADDR_MASK  8'hc0
`define LCDP_CMD_ADDR_LO    8'hc0

// ********************************************
// Reset values and timing counts
// ********************************************
`define LCDP_FILL_CHAR      8'h20
`define LCDP_RAM_DEPTH      7'h50
`define LCDP_RAM_LAST       7'h4f
`define LCDP_CLEAR_CYCLES   7'h55
`define LCDP_DUTY_RESET     3'h5
`define LCDP_DUTY_11        3'h4
`define LCDP_FRAME_360      9'h168
`define LCDP_FRAME_352      9'h160
`define LCDP_NIB_ZERO_RUN   2'h3

`endif

// *** rtl/lcdp_port.v ***
`timescale 1ns/1ps
`include "lcdp_defs.vh"

module lcdp_port #(
    parameter RC_EXTRES_DIV = 6250,
    parameter RC_INTRES_DIV = 6250,
    // Arbitrary neutral identity value.
    parameter [4:0] ID_UPPER = 5'h15
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Mode and clock source straps
    input  wire       ifaceModePinA,
    input  wire       ifaceModePinB,
    input  wire [1:0] clkSourceSel,
    input  wire       extOpClk,
    // Serial link
    input  wire       serialSelN,
    input  wire       serialData,
    input  wire       serialClk,
    // 4-bit bus; bit 0 doubles as the id select pin
    input  wire [3:0] nibbleBus,
    input  wire       busEnable,
    input  wire       busRegSelect,
    // Display RAM read port
    input  wire [6:0] readAddr,
    output reg  [7:0] readData,
    // Status and decoded outputs
    output reg        busyIndicator,
    output reg        segmentOutputsGround,
    output reg        oscOutPin,
    output reg        frameTick,
    output reg  [2:0] dutySelectField,
    output reg  [6:0] addressPointer,
    output reg        instrStrobe,
    output reg  [7:0] instrCode
);

// ********************************************
// Reset and input synchronisers
// ********************************************
reg  [1:0] rstSync;
wire       rstnInt = rstSync[1];

always @(posedge clk or negedge rstn) begin
    if (!rstn)
        rstSync <= 2'h0;
    else
        rstSync <= {rstSync[0], 1'b1};
end

localparam NSYNC = 13;
// The select line idles high, so its stages reset high to avoid a false select.
localparam [NSYNC-1:0] SYNC_IDLE = 13'h0200;
wire [NSYNC-1:0] pinRaw = {ifaceModePinA, ifaceModePinB, extOpClk,
                           serialSelN, serialData, serialClk,
                           nibbleBus, busEnable, busRegSelect, 1'b0};
reg  [NSYNC-1:0] pinMeta;
reg  [NSYNC-1:0] pinSync;

always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
        pinMeta <= SYNC_IDLE;
        pinSync <= SYNC_IDLE;
    end else begin
        pinMeta <= pinRaw;
        pinSync <= pinMeta;
    end
end

wire       modeA   = pinSync[12];
wire       modeB   = pinSync[11];
wire       extSy   = pinSync[10];
wire       selNSy  = pinSync[9];
wire       sdaSy   = pinSync[8];
wire       sclSy   = pinSync[7];
wire [3:0] nibSy   = pinSync[6:3];
wire       enSy    = pinSync[2];
wire       rsSy    = pinSync[1];
wire       serMode = !modeA && !modeB;
wire       nibMode = modeA && !modeB;

reg        extD_r;
reg        selND_r;
reg        sclD_r;
reg        enD_r;

always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
        extD_r  <= 1'b0;
        selND_r <= 1'b1;
        sclD_r  <= 1'b0;
        enD_r   <= 1'b0;
    end else begin
        extD_r  <= extSy;
        selND_r <= selNSy;
        sclD_r  <= sclSy;
        enD_r   <= enSy;
    end
end

// ********************************************
// Operating clock source
// ********************************************
// The RC oscillator is modelled by a divider of the system clock.
reg  [15:0] divCnt_r;
wire [15:0] divLast = (clkSourceSel == `LCDP_SRC_RC_EXTRES) ?
                      RC_EXTRES_DIV[15:0] - 16'h1 :
                      RC_INTRES_DIV[15:0] - 16'h1;
wire        divHit  = (divCnt_r >= divLast);
wire        opClkEn = (clkSourceSel == `LCDP_SRC_EXT) ?
                      (extSy && !extD_r) : divHit;

always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
        divCnt_r  <= 16'h0;
        oscOutPin <= 1'b0;
    end else begin
        divCnt_r <= divHit ? 16'h0 : divCnt_r + 16'h1;
        if (opClkEn)
            oscOutPin <= !oscOutPin;
    end
end

// ********************************************
// Serial receiver
// ********************************************
reg  [7:0] serShift_r;
reg  [2:0] serBits_r;
reg        serStart_r;
reg        serSel_r;
reg        serRs_r;
reg        serByteV;
reg  [7:0] serByte;
wire [7:0] serNxt = {serShift_r[6:0], sdaSy};
wire [5:0] ownId  = {ID_UPPER, nibSy[0]};

always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
        serShift_r <= 8'h0;
        serBits_r  <= 3'h0;
        serStart_r <= 1'b1;
        serSel_r   <= 1'b0;
        serRs_r    <= 1'b0;
        serByteV   <= 1'b0;
        serByte    <= 8'h0;
    end else begin
        serByteV <= 1'b0;
        if (selNSy || !serMode) begin
            serBits_r  <= 3'h0;
            serStart_r <= 1'b1;
            serSel_r   <= 1'b0;
        end else if (selND_r) begin
            serBits_r  <= 3'h0;
            serStart_r <= 1'b1;
        end else if (sclSy && !sclD_r) begin
            serShift_r <= serNxt;
            serBits_r  <= serBits_r + 3'h1;
            if (serBits_r == 3'h7) begin
                serStart_r <= 1'b0;
                if (serStart_r) begin
                    serSel_r <= (serNxt[7:2] == ownId);
                    serRs_r  <= serNxt[`LCDP_SB_RS_POS];
                end else begin
                    serByteV <= serSel_r;
                    serByte  <= serNxt;
                end
            end
        end
    end
end

// ********************************************
// 4-bit bus receiver
// ********************************************
reg        nibLow_r;
reg  [3:0] nibHigh_r;
reg  [1:0] nibZero_r;
reg        nibByteV;
reg  [7:0] nibByte;
reg        nibRs;

always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
        nibLow_r  <= 1'b0;
        nibHigh_r <= 4'h0;
        nibZero_r <= 2'h0;
        nibByteV  <= 1'b0;
        nibByte   <= 8'h0;
        nibRs     <= 1'b0;
    end else begin
        nibByteV <= 1'b0;
        if (!nibMode) begin
            nibLow_r  <= 1'b0;
            nibZero_r <= 2'h0;
        end else if (!enSy && enD_r) begin
            // Only instruction-side zero nibbles count as NO_OP_COMMAND writes.
            if (nibSy == 4'h0 && !rsSy &&
                nibZero_r == `LCDP_NIB_ZERO_RUN) begin
                nibLow_r  <= 1'b0;
                nibZero_r <= 2'h0;
            end else begin
                nibZero_r <= (nibSy == 4'h0 && !rsSy) ?
                             nibZero_r + 2'h1 : 2'h0;
                nibLow_r  <= !nibLow_r;
                if (!nibLow_r) begin
                    nibHigh_r <= nibSy;
                end else begin
                    nibByteV <= 1'b1;
                    nibByte  <= {nibHigh_r, nibSy};
                    nibRs    <= rsSy;
                end
            end
        end
    end
end

// ********************************************
// Execution, clear sequence and display RAM
// ********************************************
reg  [7:0] textRam [0:79];
reg  [6:0] clrCnt_r;
reg        clearing_r;
wire       byteV   = serByteV || nibByteV;
wire [7:0] byteD   = serByteV ? serByte : nibByte;
wire       byteRs  = serByteV ? serRs_r : nibRs;
wire       accept  = byteV && !busyIndicator;
wire       clrWr   = clearing_r && opClkEn && (clrCnt_r < `LCDP_RAM_DEPTH);
wire       ramWr   = accept && byteRs;

always @(posedge clk) begin
    if (clrWr)
        textRam[clrCnt_r] <= `LCDP_FILL_CHAR;
    else if (ramWr)
        textRam[addressPointer] <= byteD;
    readData <= textRam[readAddr];
end

always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
        clearing_r           <= 1'b1;
        clrCnt_r             <= 7'h0;
        busyIndicator        <= 1'b1;
        segmentOutputsGround <= 1'b1;
        addressPointer       <= 7'h0;
        dutySelectField      <= `LCDP_DUTY_RESET;
        instrStrobe          <= 1'b0;
        instrCode            <= 8'h0;
    end else begin
        instrStrobe <= 1'b0;
        if (clearing_r) begin
            if (opClkEn) begin
                if (clrCnt_r == `LCDP_CLEAR_CYCLES - 7'h1) begin
                    clearing_r    <= 1'b0;
                    busyIndicator <= 1'b0;
                    segmentOutputsGround <= 1'b0;
                    addressPointer <= 7'h0;
                end
                clrCnt_r <= clrCnt_r + 7'h1;
            end
        end else if (accept && byteRs) begin
            addressPointer <= (addressPointer == `LCDP_RAM_LAST) ?
                              7'h0 : addressPointer + 7'h1;
        end else if (accept) begin
            instrStrobe <= (byteD != `LCDP_CMD_NOP);
            instrCode   <= byteD;
            if (byteD == `LCDP_CMD_CLEAR) begin
                clearing_r    <= 1'b1;
                clrCnt_r      <= 7'h0;
                busyIndicator <= 1'b1;
            end else if (byteD == `LCDP_CMD_HOME) begin
                addressPointer <= 7'h0;
            end else if ((byteD & `LCDP_CMD_DUTY_MASK) == `LCDP_CMD_DUTY) begin
                dutySelectField <= byteD[2:0];
            end else if ((byteD & `LCDP_CMD_ADDR_MASK) ==
                         `LCDP_CMD_ADDR_LO) begin
                addressPointer <= {1'b0, byteD[5:0]};
            end
        end
    end
end

// ********************************************
// Frame timer
// ********************************************
reg  [8:0] frameCnt_r;
wire [8:0] frameLen = (dutySelectField == `LCDP_DUTY_11) ?
                      `LCDP_FRAME_352 : `LCDP_FRAME_360;

always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
        frameCnt_r <= 9'h0;
        frameTick  <= 1'b0;
    end else begin
        frameTick <= 1'b0;
        if (opClkEn) begin
            if (frameCnt_r >= frameLen - 9'h1) begin
                frameCnt_r <= 9'h0;
                frameTick  <= 1'b1;
            end else begin
                frameCnt_r <= frameCnt_r + 9'h1;
            end
        end
    end
end

endmodule

// *** test/lcdp_port_properties.sv ***
`timescale 1ns/1ps
// ****************************************
// Port properties
// ****************************************
module lcdp_port_chk #(
    parameter RC_EXTRES_DIV = 6250
) (
    // Watched ports
    input wire       clk,
    input wire       rstn,
    input wire [1:0] clkSourceSel,
    input wire       busyIndicator,
    input wire       segmentOutputsGround,
    input wire       oscOutPin,
    input wire       frameTick,
    input wire [2:0] dutySelectField,
    input wire       instrStrobe,
    input wire [7:0] instrCode
);
    int       busyCnt_r;
    int       gap_r;
    int       idle_r;
    reg       frameOk_r;
    reg       oscLast_r;
    reg [2:0] dutyLast_r;
    // A frame is only judged when duty held still and no clear ran in it.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busyCnt_r <= 0;
            gap_r <= 0;
            idle_r <= 0;
            frameOk_r <= 1'b0;
            oscLast_r <= 1'b0;
            dutyLast_r <= 3'h5;
        end else begin
            busyCnt_r <= busyIndicator ? busyCnt_r + 1 : 0;
            gap_r <= frameTick ? 1 : gap_r + 1;
            idle_r <= (oscOutPin != oscLast_r) ? 0 : idle_r + 1;
            oscLast_r <= oscOutPin;
            dutyLast_r <= dutySelectField;
            if (dutySelectField != dutyLast_r || busyIndicator)
                frameOk_r <= 1'b0;
            else if (frameTick)
                frameOk_r <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_clear;
        instrStrobe && instrCode == 8'h01;
    endsequence
    sequence s_busy_on;
        busyIndicator;
    endsequence
    property p_reset_vals;
        $rose(rstn) |-> busyIndicator && segmentOutputsGround
            && dutySelectField == 3'h5;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("state wrong at reset release");
    property p_seg_busy;
        segmentOutputsGround |-> busyIndicator;
    endproperty
    a_seg_busy: assert property (p_seg_busy)
        else $error("drives grounded outside init");
    property p_osc_runs;
        clkSourceSel == 2'h1 |-> idle_r <= 2 * RC_EXTRES_DIV + 4;
    endproperty
    a_osc_runs: assert property (p_osc_runs)
        else $error("oscillator output stopped");
    property p_clear_busy;
        s_clear |-> ##[0:4] s_busy_on;
    endproperty
    a_clear_busy: assert property (p_clear_busy)
        else $error("clear did not raise busy");
    property p_busy_len;
        $fell(busyIndicator) |-> busyCnt_r inside {[332:350]};
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length not 85 ticks");
    property p_frame_len;
        frameTick && frameOk_r && dutySelectField == dutyLast_r |->
            gap_r == (dutySelectField == 3'h4 ? 352 : 360) * RC_EXTRES_DIV;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame length wrong");
    property p_no_nop;
        instrStrobe |-> instrCode != 8'h00;
    endproperty
    a_no_nop: assert property (p_no_nop)
        else $error("no-op produced a strobe");
    property p_duty_set;
        instrStrobe && instrCode[7:3] == 5'h03 |->
            ##[0:2] dutySelectField == instrCode[2:0];
    endproperty
    a_duty_set: assert property (p_duty_set)
        else $error("duty field not updated");
    property p_busy_quiet;
        busyIndicator && $past(busyIndicator, 3) |-> !instrStrobe;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("instruction taken while busy");
endmodule
bind lcdp_port lcdp_port_chk #(.RC_EXTRES_DIV(RC_EXTRES_DIV)) chk_i (
    .clk, .rstn, .clkSourceSel, .busyIndicator, .segmentOutputsGround,
    .oscOutPin, .frameTick, .dutySelectField, .instrStrobe, .instrCode);

// *** test/lcdp_host.sv ***
`timescale 1ns/1ps
// ****************************************
// Host model for serial link and nibble bus
// ****************************************
module lcdp_host (
    // Clock
    input wire       clk,
    // Serial link
    output reg       serialSelN = 1'b1,
    output reg       serialData = 1'b0,
    output reg       serialClk = 1'b0,
    // Nibble bus
    output reg [3:0] nibbleBus = 4'h1,
    output reg       busEnable = 1'b0,
    output reg       busRegSelect = 1'b0
);
    task automatic sendBit(input b);
        serialData <= b;
        repeat (12) @(posedge clk);
        serialClk <= 1'b1;
        repeat (13) @(posedge clk);
        serialClk <= 1'b0;
    endtask
    task automatic serFrame(input [5:0] id, input rs, input idPin,
                            input [7:0] d);
        reg [15:0] w;
        w = {id, rs, 1'b0, d};
        nibbleBus <= {3'h0, idPin};
        serialSelN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 15; i >= 0; i--) sendBit(w[i]);
        repeat (13) @(posedge clk);
        serialSelN <= 1'b1;
        // A released line must not keep showing its last bit.
        serialData <= ~w[0];
        repeat (4) @(posedge clk);
    endtask
    task automatic nibble(input rs, input [3:0] n);
        busRegSelect <= rs;
        nibbleBus <= n;
        busEnable <= 1'b1;
        repeat (4) @(posedge clk);
        busEnable <= 1'b0;
        repeat (8) @(posedge clk);
        nibbleBus <= ~n;
        repeat (2) @(posedge clk);
    endtask
    task automatic nibByte(input rs, input [7:0] b);
        nibble(rs, b[7:4]);
        nibble(rs, b[3:0]);
    endtask
    task automatic resync;
        repeat (4) nibble(1'b0, 4'h0);
    endtask
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
// ****************************************
// Bench for the display host port
// ****************************************
module tb;
    // Arbitrary identity value.
    localparam [4:0] ID_UP = 5'h15;
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg        modeA = 1'b0;
    reg  [6:0] rdAddr = 7'h00;
    wire       selN, sDat, sClk, en, rs, busy, segGnd, osc, fTick, stb;
    wire [3:0] nib;
    wire [7:0] rdData, code;
    wire [2:0] duty;
    wire [6:0] ptr;
    int        n_mismatch = 0;
    int        compares = 0;
    int        nStrobe = 0;
    int        t;
    reg  [7:0] duties [6] = '{8'h18, 8'h19, 8'h1a, 8'h1c, 8'h1d, 8'h1e};
    always #2.5 clk = ~clk;
    always @(posedge clk) if (stb === 1'b1) nStrobe <= nStrobe + 1;
    lcdp_host lcdp_host_i (.clk(clk), .serialSelN(selN), .serialData(sDat),
        .serialClk(sClk), .nibbleBus(nib), .busEnable(en),
        .busRegSelect(rs));
    lcdp_port #(.RC_EXTRES_DIV(4), .RC_INTRES_DIV(4), .ID_UPPER(ID_UP))
    lcdp_port_i (.clk(clk), .rstn(rstn), .ifaceModePinA(modeA),
        .ifaceModePinB(1'b0), .clkSourceSel(2'h1), .extOpClk(1'b0),
        .serialSelN(selN), .serialData(sDat), .serialClk(sClk),
        .nibbleBus(nib), .busEnable(en), .busRegSelect(rs),
        .readAddr(rdAddr), .readData(rdData), .busyIndicator(busy),
        .segmentOutputsGround(segGnd), .oscOutPin(osc), .frameTick(fTick),
        .dutySelectField(duty), .addressPointer(ptr), .instrStrobe(stb),
        .instrCode(code));
    task chk(input [7:0] got, input [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rd(input [6:0] a, input [7:0] exp);
        rdAddr <= a;
        repeat (3) @(posedge clk);
        chk(rdData, exp);
    endtask
    task frame(input idBit, input rsBit, input idPin, input [7:0] d);
        lcdp_host_i.serFrame({ID_UP, idBit}, rsBit, idPin, d);
        repeat (8) @(posedge clk);
    endtask
    task waitIdle;
        t = 0;
        while (busy !== 1'b0 && t < 2000) begin
            @(posedge clk);
            t++;
        end
    endtask
    task end_sim;
        $display("Mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clk);
        chk({busy, segGnd, 3'h0, duty}, 8'hc5);
        rstn <= 1'b1;
        @(posedge clk);
        waitIdle;
        chk({7'h0, t inside {[330:350]}}, 8'h01);
        // No glyph RAM write and no power control is sent.
        // The host must leave 500 operating clocks before talking.
        repeat (2000) @(posedge clk);
        rd(7'h00, 8'h20);
        rd(7'h4f, 8'h20);
        chk({7'h0, segGnd}, 8'h00);
        foreach (duties[i]) begin
            frame(1'b1, 1'b0, 1'b1, duties[i]);
            repeat (4400) @(posedge clk);
            chk({5'h0, duty}, {5'h0, duties[i][2:0]});
        end
        frame(1'b0, 1'b0, 1'b1, 8'h1d);
        chk({5'h0, duty}, 8'h06);
        frame(1'b0, 1'b0, 1'b0, 8'h1c);
        chk({5'h0, duty}, 8'h04);
        frame(1'b1, 1'b0, 1'b1, 8'hc5);
        frame(1'b1, 1'b1, 1'b1, 8'ha5);
        chk({1'b0, ptr}, 8'h06);
        rd(7'h05, 8'ha5);
        t = nStrobe;
        frame(1'b1, 1'b0, 1'b1, 8'h00);
        chk({7'h0, nStrobe == t}, 8'h01);
        frame(1'b1, 1'b0, 1'b1, 8'h01);
        chk({7'h0, busy}, 8'h01);
        waitIdle;
        rd(7'h05, 8'h20);
        modeA <= 1'b1;
        repeat (4) @(posedge clk);
        lcdp_host_i.nibByte(1'b0, 8'h1a);
        chk({5'h0, duty}, 8'h02);
        lcdp_host_i.nibble(1'b0, 4'h1);
        lcdp_host_i.resync;
        lcdp_host_i.nibByte(1'b0, 8'h19);
        chk({5'h0, duty}, 8'h01);
        lcdp_host_i.nibByte(1'b0, 8'hc0);
        lcdp_host_i.nibByte(1'b1, 8'h3c);
        rd(7'h00, 8'h3c);
        frame(1'b1, 1'b0, 1'b1, 8'h1d);
        chk({5'h0, duty}, 8'h01);
        end_sim;
    end
endmodule
